// file: inc/crm_defs.svh
// Constants for the clock-request pin map and lane owner block.
// Assumes a single 50 MHz clock and the plain register port of crm_top.
//
// Contract
// R1: Enable bit per port selects pin routing
// R2: Disabled port sees de-asserted request
// R3: Five-bit select value n picks pin n
// R4: Select field ignored while enable clear
// R5: Unimplemented pin encodings are reserved
// R6: Software never maps two ports together
// R7: Software never selects unsupported pins
// R8: Select fields reset to port minus one
// R9: Five fields per word, reserved gaps
// R10: Four-bit read-only owner per lane
// R11: Owner codes: PCIe, USB, SATA, GbE, none
// R12: Owner fields and upper half reset zero
// R13: Lock input freezes enable and selects
`ifndef CRM_DEFS_SVH
`define CRM_DEFS_SVH

`define CRM_ADDR_W          12
`define CRM_PORTS           12
`define CRM_PINS            16
`define CRM_LANES           12
`define CRM_OFS_ENABLE      12'h100
`define CRM_OFS_SEL1        12'h108
`define CRM_OFS_SEL2        12'h10C
`define CRM_OFS_SEL3        12'h110
`define CRM_OFS_LANE1       12'h300
`define CRM_OFS_LANE2       12'h304
`define CRM_ENABLE_MASK     32'h00000FFF
`define CRM_SEL_MASK        32'h1F7DF7DF
`define CRM_SEL3_MASK       32'h000007DF
`define CRM_LANE2_MASK      32'h0000FFFF
`define CRM_ENABLE_RST      32'h00000000
`define CRM_SEL1_RST        32'h040C2040
`define CRM_SEL2_RST        32'h09207185
`define CRM_SEL3_RST        32'h000002CA
`define CRM_SEL_W           5
`define CRM_SEL_PITCH       6
`define CRM_SEL_PER_WORD    5
`define CRM_SEL_LSB0        5'h00
`define CRM_SEL_LSB1        5'h06
`define CRM_SEL_LSB2        5'h0C
`define CRM_SEL_LSB3        5'h12
`define CRM_SEL_LSB4        5'h18
`define CRM_OWNER_W         4

`endif

// file: inc/crm_pkg.sv
// Types for the clock-request pin map and lane owner block.
// Constants live in crm_defs.svh.
package crm_pkg;

  typedef enum logic [3:0] {
    CRM_OWNER_PCIE  = 4'h0,
    CRM_OWNER_USB   = 4'h1,
    CRM_OWNER_SATA  = 4'h2,
    CRM_OWNER_GBE   = 4'h3,
    CRM_OWNER_NONE  = 4'hF
  } crm_owner_type;

  typedef logic [11:0][3:0] crm_lanes_type;

  typedef struct packed {
    logic [11:0]      addr;
    logic [31:0]      wdata;
    logic             wr;
    logic             rd;
  } crm_bus_type;

  typedef struct packed {
    logic [11:0]      enable;
    logic [2:0][31:0] sel;
    crm_lanes_type    lanes;
    logic [15:0]      pin_s1;
    logic [15:0]      pin_s2;
    logic             lock_s1;
    logic             lock_s2;
    logic             locked;
    logic [11:0]      port_req;
    logic [31:0]      rdata;
  } crm_state_type;

endpackage

// file: core/crm_top.sv
// Clock-request pin map for twelve root ports and lane owner status.
// Pins and the lock input are asynchronous and are synchronised here;
// lane owner codes come from logic on the same clock.
//
// Local design decision: the address-and-strobe port.
`timescale 1ns/1ps
`include "crm_defs.svh"

module crm_top (
  input  wire logic                  clock,
  input  wire logic                  nrst,
  input  wire crm_pkg::crm_bus_type  bus,
  output logic [31:0]                rdata,
  input  wire logic                  cfg_lock,
  input  wire logic [15:0]           clkreq_pin_n,
  input  wire crm_pkg::crm_lanes_type lane_owner_in,
  output logic [11:0]                port_clkreq
);

  localparam crm_pkg::crm_state_type RST = '{
    enable:   12'h000,
    sel:      {`CRM_SEL3_RST, `CRM_SEL2_RST, `CRM_SEL1_RST}, // [R8]
    lanes:    '0,                                            // [R12]
    pin_s1:   16'hFFFF,
    pin_s2:   16'hFFFF,
    lock_s1:  1'b0,
    lock_s2:  1'b0,
    locked:   1'b0,
    port_req: 12'h000,
    rdata:    32'h00000000
  };

  crm_pkg::crm_state_type st_r;
  crm_pkg::crm_state_type st_nxt;

  // Word that holds each port's select field, five ports to a word
  function automatic logic [1:0] sel_word_of(input int p);
    logic [1:0] w;

    w = 2'h0;
    case (p)
      0:       w = 2'h0;
      1:       w = 2'h0;
      2:       w = 2'h0;
      3:       w = 2'h0;
      4:       w = 2'h0;
      5:       w = 2'h1;
      6:       w = 2'h1;
      7:       w = 2'h1;
      8:       w = 2'h1;
      9:       w = 2'h1;
      10:      w = 2'h2;
      11:      w = 2'h2;
      default: w = 2'h0;
    endcase
    return w;
  endfunction

  // Lowest bit of each port's field; one reserved bit between fields
  function automatic logic [4:0] sel_lsb_of(input int p);
    logic [4:0] lsb;

    lsb = 5'h00;
    case (p)
      0:       lsb = `CRM_SEL_LSB0;
      1:       lsb = `CRM_SEL_LSB1;
      2:       lsb = `CRM_SEL_LSB2;
      3:       lsb = `CRM_SEL_LSB3;
      4:       lsb = `CRM_SEL_LSB4;
      5:       lsb = `CRM_SEL_LSB0;
      6:       lsb = `CRM_SEL_LSB1;
      7:       lsb = `CRM_SEL_LSB2;
      8:       lsb = `CRM_SEL_LSB3;
      9:       lsb = `CRM_SEL_LSB4;
      10:      lsb = `CRM_SEL_LSB0;
      11:      lsb = `CRM_SEL_LSB1;
      default: lsb = 5'h00;
    endcase
    return lsb;
  endfunction

  function automatic logic [4:0] sel_of(input logic [2:0][31:0] s,
                                        input int                p);
    logic [31:0] word;
    logic [4:0]  lsb;

    word   = s[sel_word_of(p)];
    lsb    = sel_lsb_of(p);
    sel_of = word[lsb +: `CRM_SEL_W];
  endfunction

  // Codes from 16 up name pins that are not built
  function automatic logic sel_is_reserved(input logic [4:0] sel);
    return sel >= 5'(`CRM_PINS);
  endfunction

  // One port's request: pins are active low, the request is active high
  function automatic logic route_one(input logic        en,
                                     input logic [4:0]  sel,
                                     input logic [15:0] pins_n);
    logic req;

    req = 1'b0;
    if (!en) begin
      req = 1'b0; // [R2] [R4]
    end else if (sel_is_reserved(sel)) begin
      // Reserved codes route nothing rather than alias a real pin
      req = 1'b0; // [R5]
    end else begin
      req = ~pins_n[sel[3:0]]; // [R1] [R3]
    end
    return req;
  endfunction

  // Requests for all twelve ports, from the synchronised pins only
  function automatic logic [11:0] route_all(input crm_pkg::crm_state_type s);
    logic [11:0] r;
    logic [4:0]  sel;

    r   = 12'h000;
    sel = 5'h00;
    for (int p = 0; p < `CRM_PORTS; p++) begin
      sel  = sel_of(s.sel, p); // [R3]
      r[p] = route_one(s.enable[p], sel, s.pin_s2);
    end
    return r;
  endfunction

  // Status word 1 carries lanes 0 to 7, lane 0 lowest
  function automatic logic [31:0] lanes_lo(input crm_pkg::crm_lanes_type l);
    logic [31:0] v;

    v        = 32'h00000000;
    v[3:0]   = l[0];
    v[7:4]   = l[1];
    v[11:8]  = l[2];
    v[15:12] = l[3];
    v[19:16] = l[4];
    v[23:20] = l[5];
    v[27:24] = l[6];
    v[31:28] = l[7]; // [R10]
    return v;
  endfunction

  // Status word 2 carries lanes 8 to 11; its upper half is reserved
  function automatic logic [31:0] lanes_hi(input crm_pkg::crm_lanes_type l);
    logic [31:0] v;

    v        = 32'h00000000; // [R12]
    v[3:0]   = l[8];
    v[7:4]   = l[9];
    v[11:8]  = l[10];
    v[15:12] = l[11];
    return v;
  endfunction

  // Select word as read; gaps read zero even if storage ever held ones
  function automatic logic [31:0] sel_view(input logic [31:0] w);
    logic [31:0] v;

    v        = 32'h00000000;
    v[4:0]   = w[4:0];
    v[10:6]  = w[10:6];
    v[16:12] = w[16:12];
    v[22:18] = w[22:18];
    v[28:24] = w[28:24]; // [R9]
    return v;
  endfunction

  // Read mux; unmapped offsets read zero
  function automatic logic [31:0] read_of(input crm_pkg::crm_state_type s,
                                          input logic [11:0]            a);
    logic [31:0] v;

    v = 32'h00000000;
    if (a == `CRM_OFS_ENABLE) begin
      v = {20'h00000, s.enable};
    end else if (a == `CRM_OFS_SEL1) begin
      v = sel_view(s.sel[0]);
    end else if (a == `CRM_OFS_SEL2) begin
      v = sel_view(s.sel[1]);
    end else if (a == `CRM_OFS_SEL3) begin
      v = sel_view(s.sel[2]) & `CRM_SEL3_MASK;
    end else if (a == `CRM_OFS_LANE1) begin
      v = lanes_lo(s.lanes); // [R10]
    end else if (a == `CRM_OFS_LANE2) begin
      v = lanes_hi(s.lanes); // [R12]
    end
    return v;
  endfunction

  // Writable bits per offset; reserved and read-only bits are never kept
  function automatic logic [31:0] write_mask_of(input logic [11:0] a);
    logic [31:0] m;

    m = 32'h00000000;
    if (a == `CRM_OFS_ENABLE) begin
      m = `CRM_ENABLE_MASK; // [R1]
    end else if (a == `CRM_OFS_SEL1) begin
      m = `CRM_SEL_MASK; // [R9]
    end else if (a == `CRM_OFS_SEL2) begin
      m = `CRM_SEL_MASK;
    end else if (a == `CRM_OFS_SEL3) begin
      m = `CRM_SEL3_MASK;
    end
    return m;
  endfunction

  // Keeps the bits outside the mask and takes the ones inside it
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] wdata,
                                        input logic [31:0] mask);
    return (old & ~mask) | (wdata & mask);
  endfunction

  // Applies one write; the lane status offsets are read-only and drop it
  function automatic crm_pkg::crm_state_type write_of(
    input crm_pkg::crm_state_type s,
    input logic [11:0]            a,
    input logic [31:0]            d);
    crm_pkg::crm_state_type n;
    logic [31:0]            m;

    n = s;
    m = write_mask_of(a);
    if (a == `CRM_OFS_ENABLE) begin
      n.enable = 12'(merge({20'h00000, s.enable}, d, m)); // [R1]
    end else if (a == `CRM_OFS_SEL1) begin
      n.sel[0] = merge(s.sel[0], d, m); // [R9]
    end else if (a == `CRM_OFS_SEL2) begin
      n.sel[1] = merge(s.sel[1], d, m);
    end else if (a == `CRM_OFS_SEL3) begin
      n.sel[2] = merge(s.sel[2], d, m);
    end
    return n;
  endfunction

  // Two flops for the pins and the lock before any logic reads them
  function automatic crm_pkg::crm_state_type sync_of(
    input crm_pkg::crm_state_type s,
    input logic [15:0]            pins_n,
    input logic                   lock);
    crm_pkg::crm_state_type n;

    n         = s;
    n.pin_s1  = pins_n;
    n.pin_s2  = s.pin_s1;
    n.lock_s1 = lock;
    n.lock_s2 = s.lock_s1;
    // Sticky until reset so a glitching source cannot reopen writes
    if (s.lock_s2) begin
      n.locked = 1'b1; // [R13]
    end
    return n;
  endfunction

  always_comb begin
    st_nxt       = sync_of(st_r, clkreq_pin_n, cfg_lock);
    st_nxt.lanes = lane_owner_in; // [R10] [R11]
    // A write still lands in the cycle before the lock flag rises
    if (bus.wr && !st_r.locked) begin
      st_nxt = write_of(st_nxt, bus.addr, bus.wdata); // [R13]
    end
    // Read data stand for one cycle only
    st_nxt.rdata = 32'h00000000;
    if (bus.rd) begin
      st_nxt.rdata = read_of(st_r, bus.addr);
    end
    st_nxt.port_req = route_all(st_r); // [R2] [R4]
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      st_r <= RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign rdata       = st_r.rdata;
  assign port_clkreq = st_r.port_req;

endmodule

// file: sim/crm_top_assertions.sv
// Port checker for crm_top; bound to every instance at the foot.
`timescale 1ns/1ps
module crm_chk (
  input wire logic                 clock,
  input wire logic                 nrst,
  input wire crm_pkg::crm_bus_type bus,
  input wire logic [31:0]          rdata
);
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  wire logic [31:0] gap = rdata & 32'hE0820820;
  sequence rd_at(logic [11:0] a);
    bus.rd && bus.addr == a;
  endsequence
  a_rd_idle: assert property (!$past(bus.rd) |-> rdata == '0)
    else $error("read data outside its slot");
  a_write_quiet: assert property (bus.wr |=> rdata == '0)
    else $error("read data after a write");
  a_en_gap: assert property (rd_at(12'h100) |=> !rdata[31:12])
    else $error("enable reserved bits set");
  a_sel1_gap: assert property (rd_at(12'h108) |=> !gap)
    else $error("select word 1 gap set");
  a_sel2_gap: assert property (rd_at(12'h10C) |=> !gap)
    else $error("select word 2 gap set");
  a_sel3_gap: assert property (rd_at(12'h110) |=> !rdata[31:11])
    else $error("select word 3 top set");
  a_lane2_top: assert property (rd_at(12'h304) |=> !rdata[31:16])
    else $error("lane status top set");
  a_hole_zero: assert property (rd_at(12'h104) |=> rdata == '0)
    else $error("unmapped read not zero");
endmodule
bind crm_top crm_chk chk (.clock, .nrst, .bus, .rdata);

// file: sim/crm_far.sv
// Far side: request pins from a bench vector, fixed lane owner codes.
`timescale 1ns/1ps
module crm_far (
  input  wire logic [15:0]       req,
  output logic [15:0]            clkreq_pin_n,
  output crm_pkg::crm_lanes_type lane_owner_in
);
  assign clkreq_pin_n = ~req; // Pins are active low
  assign lane_owner_in = 48'hF3210F3210F3; // Every owner code two or three times
endmodule

// file: sim/tb_crm_top.sv
// Bench for crm_top; crm_far drives pins, checker is bound.
`timescale 1ns/1ps
module tb_crm_top;
  logic                   clock = 1'b0, nrst = 1'b0, cfg_lock = 1'b0;
  crm_pkg::crm_bus_type   bus = '0;
  logic [31:0]            rdata;
  logic [15:0]            req = '0, clkreq_pin_n;
  crm_pkg::crm_lanes_type lane_owner_in;
  logic [11:0]            port_clkreq;
  int                     err_total, total_checks;
  crm_top dut (.clock, .nrst, .bus, .rdata, .cfg_lock, .clkreq_pin_n,
    .lane_owner_in, .port_clkreq);
  crm_far far (.req, .clkreq_pin_n, .lane_owner_in);
  initial forever #10 clock = ~clock;
  task automatic chk(string n, logic [31:0] e, s);
    total_checks++;
    if (s !== e) err_total++;
    if (s !== e) $display("unexpected %s: expected %h seen %h", n, e, s);
  endtask
  task automatic op(logic w, logic [11:0] a, logic [31:0] d, logic [11:0] p);
    @(posedge clock) bus <= '{a, d, w, !w};
    @(posedge clock) bus <= '0;
    #1 if (!w) chk("rdata", d, rdata);
    @(posedge clock) #1 chk("port_clkreq", {20'h0, p}, {20'h0, port_clkreq});
  endtask
  task automatic t_regs;
    op(1'b1, 12'h108, 32'hE48E2860, 12'h000);
    op(1'b0, 12'h108, 32'h040C2040, 12'h000);
    op(1'b1, 12'h300, 32'hFFFFFFFF, 12'h000);
    op(1'b0, 12'h300, 32'h0F3210F3, 12'h000);
    op(1'b0, 12'h304, 32'h0000F321, 12'h000);
    op(1'b0, 12'h104, 32'h00000000, 12'h000);
    $display("register test done");
  endtask
  task automatic t_route;
    @(posedge clock) req <= 16'h0008;
    op(1'b1, 12'h100, 32'h00000FFF, 12'h008);
    op(1'b1, 12'h108, 32'h04002043, 12'h001);
    op(1'b1, 12'h100, 32'h00000FFE, 12'h000);
    @(posedge clock) req <= 16'h8000;
    op(1'b1, 12'h110, 32'h000003CA, 12'h800);
    @(posedge clock) cfg_lock <= 1'b1;
    op(1'b0, 12'h110, 32'h000003CA, 12'h800);
    op(1'b1, 12'h100, 32'h00000000, 12'h800);
    op(1'b0, 12'h100, 32'h00000FFE, 12'h800);
    $display("routing and lock test done");
  endtask
  task automatic t_reset;
    // Reset in mid-run must clear the lock and restore the map
    @(posedge clock) begin
      nrst     <= 1'b0;
      cfg_lock <= 1'b0;
      req      <= 16'hFFFF;
    end
    @(posedge clock) nrst <= 1'b1;
    op(1'b0, 12'h100, 32'h00000000, 12'h000);
    op(1'b0, 12'h10C, 32'h09207185, 12'h000);
    op(1'b0, 12'h110, 32'h000002CA, 12'h000);
    op(1'b1, 12'h100, 32'h00000FFF, 12'hFFF);
    op(1'b1, 12'h108, 32'h040C205F, 12'hFFE);
    $display("mid-run reset test done");
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge clock);
    nrst <= 1'b1;
    t_regs;
    t_route;
    t_reset;
    summarize;
  end
  initial begin
    #20us err_total++; // Tests need about 1.5 us
    summarize;
  end
endmodule
